// File: pdeo_ovr_if.sv
// override and port-register bundle between the top and the resolver
// assumes both ends on the same clock, purely combinational use
`timescale 1ns/1ps
interface pdeo_ovr_if;
    pdeo_pkg::pdeo_byte_t pu_oe;
    pdeo_pkg::pdeo_byte_t pu_ov;
    pdeo_pkg::pdeo_byte_t dd_oe;
    pdeo_pkg::pdeo_byte_t dd_ov;
    pdeo_pkg::pdeo_byte_t pv_oe;
    pdeo_pkg::pdeo_byte_t pv_ov;
    pdeo_pkg::pdeo_byte_t die_oe;
    pdeo_pkg::pdeo_byte_t die_ov;
    pdeo_pkg::pdeo_byte_t port_val;
    pdeo_pkg::pdeo_byte_t port_dir;
    logic                 pu_dis;
    logic                 sleep_off;
    pdeo_pkg::pdeo_byte_t pull_en;
    pdeo_pkg::pdeo_byte_t out_en;
    pdeo_pkg::pdeo_byte_t out_val;
    pdeo_pkg::pdeo_byte_t in_en;
    modport src (output pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, die_oe, die_ov,
                 output port_val, port_dir, pu_dis, sleep_off,
                 input  pull_en, out_en, out_val, in_en);
    modport res (input  pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, die_oe, die_ov,
                 input  port_val, port_dir, pu_dis, sleep_off,
                 output pull_en, out_en, out_val, in_en);
endinterface

// File: pdeo_params.svh
// pin positions and reset values for the port d/e override block
// assumes inclusion by bare name from every file that needs them
`ifndef PDEO_PARAMS_SVH
`define PDEO_PARAMS_SVH

`define PDEO_PD_IRQ0_BIT    1
`define PDEO_PD_CAPT_BIT    0
`define PDEO_PE_DIVCLK_BIT  7
`define PDEO_PE_SDO_BIT     6
`define PDEO_PE_SDA_BIT     5
`define PDEO_PE_SCL_BIT     4
`define PDEO_PE_ACN_BIT     3
`define PDEO_PE_ACP_BIT     2
`define PDEO_PE_TX_BIT      1
`define PDEO_PE_RX_BIT      0
`define PDEO_BYTE_ZERO      8'h00
`define PDEO_NIB_ZERO       4'h0
`define PDEO_PIN_LATENCY    3

`endif

// File: pdeo_pin_model.sv
// board side of the port e pins: bench drivers, pull-ups and floating lines
// assumes pin controls from the override block and drive values from the bench
`timescale 1ns/1ps
module pdeo_pin_model (
    input  wire logic                 clk,
    input  wire pdeo_pkg::pdeo_byte_t out_en,
    input  wire pdeo_pkg::pdeo_byte_t out_val,
    input  wire pdeo_pkg::pdeo_byte_t pull_en,
    input  wire pdeo_pkg::pdeo_byte_t ext_en,
    input  wire pdeo_pkg::pdeo_byte_t ext_val,
    output pdeo_pkg::pdeo_byte_t      pin
);
    pdeo_pkg::pdeo_byte_t last_r;
    initial last_r = 8'h00;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (out_en[i]) pin[i] = out_val[i];
            else if (ext_en[i]) pin[i] = ext_val[i];
            else if (pull_en[i]) pin[i] = 1'b1;
            else pin[i] = ~last_r[i];  // floating line wanders
        end
    end
    always @(posedge clk) last_r <= pin;
endmodule

// File: pdeo_pkg.sv
// shared types for the port d/e override block
// assumes nothing beyond a systemverilog compiler
package pdeo_pkg;
    typedef logic [7:0] pdeo_byte_t;
    typedef logic [3:0] pdeo_nib_t;
endpackage

// File: pdeo_resolve.sv
// per-pin merge of peripheral overrides with port-register defaults
// assumes the top registers the results; no state here
`timescale 1ns/1ps
module pdeo_resolve (
    pdeo_ovr_if.res ovr
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // override value wins whenever its enable is set
            ovr.pull_en[i] = ovr.pu_oe[i] ? ovr.pu_ov[i]
                           : (ovr.port_val[i] & ~ovr.port_dir[i] & ~ovr.pu_dis);
            ovr.out_en[i]  = ovr.dd_oe[i] ? ovr.dd_ov[i] : ovr.port_dir[i];
            ovr.out_val[i] = ovr.pv_oe[i] ? ovr.pv_ov[i] : ovr.port_val[i];
            ovr.in_en[i]   = ovr.die_oe[i] ? ovr.die_ov[i] : ~ovr.sleep_off;
        end
    end
endmodule

// File: pdeo_top.sv
// port d bits 3..0 and port e alternate-function override logic
// assumes pin levels are asynchronous; all other inputs are on clk
`timescale 1ns/1ps
`include "pdeo_params.svh"
module pdeo_top (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire logic                 ce,
    input  wire pdeo_pkg::pdeo_byte_t pe_pin_in,
    input  wire pdeo_pkg::pdeo_nib_t  pd_pin_in,
    input  wire pdeo_pkg::pdeo_byte_t port_e_value,
    input  wire pdeo_pkg::pdeo_byte_t port_e_direction,
    input  wire pdeo_pkg::pdeo_nib_t  port_d_value,
    input  wire pdeo_pkg::pdeo_nib_t  port_d_direction,
    input  wire logic                 global_pullup_disable,
    input  wire logic                 sleep_input_off,
    input  wire logic                 ext_irq0_enable,
    input  wire logic                 clock_output_fuse,
    input  wire logic                 io_clock_divided,
    input  wire logic                 usart_sync_mode,
    input  wire logic                 usart_clock_out,
    input  wire logic                 receiver_enable,
    input  wire logic                 transmitter_enable,
    input  wire logic                 usart_transmit_data,
    input  wire logic                 serial_three_line_mode,
    input  wire logic                 serial_two_line_mode,
    input  wire logic                 serial_data_out,
    input  wire logic                 serial_clock_hold,
    input  wire logic                 serial_clock_toggle,
    input  wire logic                 start_condition_irq_enable,
    input  wire pdeo_pkg::pdeo_byte_t pin_change_mask,
    input  wire logic                 pin_change_group0_enable,
    input  wire logic                 comparator_pos_input_disable,
    input  wire logic                 comparator_neg_input_disable,
    output pdeo_pkg::pdeo_byte_t      pe_pullup,
    output pdeo_pkg::pdeo_byte_t      pe_out_en,
    output pdeo_pkg::pdeo_byte_t      pe_out_val,
    output pdeo_pkg::pdeo_nib_t       pd_pullup,
    output pdeo_pkg::pdeo_nib_t       pd_out_en,
    output pdeo_pkg::pdeo_nib_t       pd_out_val,
    output logic                      ext_irq0_input,
    output logic                      timer1_capture_input,
    output pdeo_pkg::pdeo_byte_t      pin_change_src,
    output logic                      usart_receive_data,
    output logic                      usart_ext_clock_in,
    output logic                      universal_serial_in,
    output logic                      universal_serial_clock,
    output logic                      comparator_positive_in,
    output logic                      comparator_negative_in,
    output logic                      port_e_bit4_toggle
);
    // port-register pull-up, used for port d only; port e gets it from the resolver
    function automatic logic port_pullup(input logic val, input logic dir, input logic pu_dis);
        port_pullup = val & ~dir & ~pu_dis;
    endfunction

    pdeo_pkg::pdeo_byte_t pe_s1_r, pe_s2_r, pe_s1_nxt, pe_s2_nxt;
    pdeo_pkg::pdeo_nib_t  pd_s1_r, pd_s2_r, pd_s1_nxt, pd_s2_nxt;
    pdeo_pkg::pdeo_byte_t pe_pullup_r, pe_out_en_r, pe_out_val_r;
    pdeo_pkg::pdeo_byte_t pe_pullup_nxt, pe_out_en_nxt, pe_out_val_nxt;
    pdeo_pkg::pdeo_nib_t  pd_pullup_r, pd_out_en_r, pd_out_val_r;
    pdeo_pkg::pdeo_nib_t  pd_pullup_nxt, pd_out_en_nxt, pd_out_val_nxt;
    pdeo_pkg::pdeo_byte_t pcint_r, pcint_nxt;
    logic irq0_r, irq0_nxt, capt_r, capt_nxt, rxd_r, rxd_nxt, xclk_r, xclk_nxt;
    logic sin_r, sin_nxt, sclk_r, sclk_nxt, acp_r, acp_nxt, acn_r, acn_nxt;
    logic tog_r, tog_nxt;
    pdeo_pkg::pdeo_byte_t pc_en;
    logic xclk_oe, pd1_in_en;

    pdeo_ovr_if ovr ();

    pdeo_resolve u_resolve (
        .ovr (ovr)
    );

    always_comb begin
        pc_en   = pin_change_mask & {8{pin_change_group0_enable}};
        xclk_oe = usart_sync_mode & port_e_direction[`PDEO_PE_ACP_BIT];

        ovr.port_val  = port_e_value;
        ovr.port_dir  = port_e_direction;
        ovr.pu_dis    = global_pullup_disable;
        ovr.sleep_off = sleep_input_off;
        ovr.pu_oe     = `PDEO_BYTE_ZERO;
        ovr.pu_ov     = `PDEO_BYTE_ZERO;
        ovr.dd_oe     = `PDEO_BYTE_ZERO;
        ovr.dd_ov     = `PDEO_BYTE_ZERO;
        ovr.pv_oe     = `PDEO_BYTE_ZERO;
        ovr.pv_ov     = `PDEO_BYTE_ZERO;
        ovr.die_oe    = pc_en;
        ovr.die_ov    = {8{1'b1}};

        // divided clock on pe7 regardless of port bits
        ovr.dd_oe[`PDEO_PE_DIVCLK_BIT] = clock_output_fuse;
        ovr.dd_ov[`PDEO_PE_DIVCLK_BIT] = 1'b1;
        ovr.pv_oe[`PDEO_PE_DIVCLK_BIT] = clock_output_fuse;
        ovr.pv_ov[`PDEO_PE_DIVCLK_BIT] = io_clock_divided;

        ovr.pv_oe[`PDEO_PE_SDO_BIT] = serial_three_line_mode;
        ovr.pv_ov[`PDEO_PE_SDO_BIT] = serial_data_out;

        // two-line data: driven low when data out or port bit high with dir set, else released
        ovr.pu_oe[`PDEO_PE_SDA_BIT] = serial_two_line_mode;
        ovr.dd_oe[`PDEO_PE_SDA_BIT] = serial_two_line_mode;
        ovr.dd_ov[`PDEO_PE_SDA_BIT] = (serial_data_out | port_e_value[`PDEO_PE_SDA_BIT])
                                      & port_e_direction[`PDEO_PE_SDA_BIT];
        ovr.pv_oe[`PDEO_PE_SDA_BIT] = serial_two_line_mode
                                      & port_e_direction[`PDEO_PE_SDA_BIT];
        ovr.die_oe[`PDEO_PE_SDA_BIT] = pc_en[`PDEO_PE_SDA_BIT]
                                       | start_condition_irq_enable;

        ovr.dd_oe[`PDEO_PE_SCL_BIT] = serial_two_line_mode;
        ovr.dd_ov[`PDEO_PE_SCL_BIT] = (serial_clock_hold | port_e_value[`PDEO_PE_SCL_BIT])
                                      & port_e_direction[`PDEO_PE_SCL_BIT];
        ovr.pv_oe[`PDEO_PE_SCL_BIT] = serial_two_line_mode
                                      & port_e_direction[`PDEO_PE_SCL_BIT];
        ovr.die_oe[`PDEO_PE_SCL_BIT] = pc_en[`PDEO_PE_SCL_BIT]
                                       | start_condition_irq_enable;

        // comparator disables turn inputs off unless pin-change needs them
        ovr.die_oe[`PDEO_PE_ACN_BIT] = pc_en[`PDEO_PE_ACN_BIT]
                                       | comparator_neg_input_disable;
        ovr.die_ov[`PDEO_PE_ACN_BIT] = pc_en[`PDEO_PE_ACN_BIT];
        ovr.die_oe[`PDEO_PE_ACP_BIT] = pc_en[`PDEO_PE_ACP_BIT]
                                       | comparator_pos_input_disable;
        ovr.die_ov[`PDEO_PE_ACP_BIT] = pc_en[`PDEO_PE_ACP_BIT];

        ovr.pu_oe[`PDEO_PE_ACP_BIT] = xclk_oe;
        ovr.pu_ov[`PDEO_PE_ACP_BIT] = usart_clock_out;

        ovr.pu_oe[`PDEO_PE_TX_BIT] = transmitter_enable;
        ovr.dd_oe[`PDEO_PE_TX_BIT] = transmitter_enable;
        ovr.dd_ov[`PDEO_PE_TX_BIT] = 1'b1;
        ovr.pv_oe[`PDEO_PE_TX_BIT] = transmitter_enable;
        ovr.pv_ov[`PDEO_PE_TX_BIT] = usart_transmit_data;

        ovr.pu_oe[`PDEO_PE_RX_BIT] = receiver_enable;
        ovr.pu_ov[`PDEO_PE_RX_BIT] = port_e_value[`PDEO_PE_RX_BIT]
                                     & ~global_pullup_disable;
        ovr.dd_oe[`PDEO_PE_RX_BIT] = receiver_enable;
    end

    always_comb begin
        pe_s1_nxt = pe_pin_in;
        pe_s2_nxt = pe_s1_r;
        pd_s1_nxt = pd_pin_in;
        pd_s2_nxt = pd_s1_r;

        pe_pullup_nxt  = ovr.pull_en;
        pe_out_en_nxt  = ovr.out_en;
        pe_out_val_nxt = ovr.out_val;

        // port d keeps register control on every bit
        for (int i = 0; i < 4; i++) begin
            pd_pullup_nxt[i] = port_pullup(port_d_value[i], port_d_direction[i],
                                           global_pullup_disable);
        end
        pd_out_en_nxt  = port_d_direction;
        pd_out_val_nxt = port_d_value;
        pd1_in_en      = ext_irq0_enable | ~sleep_input_off;

        irq0_nxt  = pd_s2_r[`PDEO_PD_IRQ0_BIT] & pd1_in_en;
        capt_nxt  = pd_s2_r[`PDEO_PD_CAPT_BIT] & ~sleep_input_off;
        pcint_nxt = pe_s2_r & ovr.in_en;
        rxd_nxt   = pe_s2_r[`PDEO_PE_RX_BIT] & ovr.in_en[`PDEO_PE_RX_BIT]
                    & receiver_enable;
        xclk_nxt  = pe_s2_r[`PDEO_PE_ACP_BIT] & ovr.in_en[`PDEO_PE_ACP_BIT]
                    & usart_sync_mode & ~xclk_oe;
        sin_nxt   = pe_s2_r[`PDEO_PE_SDA_BIT] & ovr.in_en[`PDEO_PE_SDA_BIT];
        sclk_nxt  = pe_s2_r[`PDEO_PE_SCL_BIT] & ovr.in_en[`PDEO_PE_SCL_BIT];
        acp_nxt   = pe_s2_r[`PDEO_PE_ACP_BIT];
        acn_nxt   = pe_s2_r[`PDEO_PE_ACN_BIT];
        tog_nxt   = serial_clock_toggle;

        if (srst) begin
            pe_s1_nxt      = `PDEO_BYTE_ZERO;
            pe_s2_nxt      = `PDEO_BYTE_ZERO;
            pd_s1_nxt      = `PDEO_NIB_ZERO;
            pd_s2_nxt      = `PDEO_NIB_ZERO;
            pe_pullup_nxt  = `PDEO_BYTE_ZERO;
            pe_out_en_nxt  = `PDEO_BYTE_ZERO;
            pe_out_val_nxt = `PDEO_BYTE_ZERO;
            // clock output stays live through reset
            pe_out_en_nxt[`PDEO_PE_DIVCLK_BIT]  = clock_output_fuse;
            pe_out_val_nxt[`PDEO_PE_DIVCLK_BIT] = clock_output_fuse & io_clock_divided;
            pd_pullup_nxt  = `PDEO_NIB_ZERO;
            pd_out_en_nxt  = `PDEO_NIB_ZERO;
            pd_out_val_nxt = `PDEO_NIB_ZERO;
            pcint_nxt      = `PDEO_BYTE_ZERO;
            irq0_nxt       = 1'b0;
            capt_nxt       = 1'b0;
            rxd_nxt        = 1'b0;
            xclk_nxt       = 1'b0;
            sin_nxt        = 1'b0;
            sclk_nxt       = 1'b0;
            acp_nxt        = 1'b0;
            acn_nxt        = 1'b0;
            tog_nxt        = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (ce || srst) begin
            pe_s1_r      <= pe_s1_nxt;
            pe_s2_r      <= pe_s2_nxt;
            pd_s1_r      <= pd_s1_nxt;
            pd_s2_r      <= pd_s2_nxt;
            pe_pullup_r  <= pe_pullup_nxt;
            pe_out_en_r  <= pe_out_en_nxt;
            pe_out_val_r <= pe_out_val_nxt;
            pd_pullup_r  <= pd_pullup_nxt;
            pd_out_en_r  <= pd_out_en_nxt;
            pd_out_val_r <= pd_out_val_nxt;
            pcint_r      <= pcint_nxt;
            irq0_r       <= irq0_nxt;
            capt_r       <= capt_nxt;
            rxd_r        <= rxd_nxt;
            xclk_r       <= xclk_nxt;
            sin_r        <= sin_nxt;
            sclk_r       <= sclk_nxt;
            acp_r        <= acp_nxt;
            acn_r        <= acn_nxt;
            tog_r        <= tog_nxt;
        end
    end

    assign pe_pullup              = pe_pullup_r;
    assign pe_out_en              = pe_out_en_r;
    assign pe_out_val             = pe_out_val_r;
    assign pd_pullup              = pd_pullup_r;
    assign pd_out_en              = pd_out_en_r;
    assign pd_out_val             = pd_out_val_r;
    assign ext_irq0_input         = irq0_r;
    assign timer1_capture_input   = capt_r;
    assign pin_change_src         = pcint_r;
    assign usart_receive_data     = rxd_r;
    assign usart_ext_clock_in     = xclk_r;
    assign universal_serial_in    = sin_r;
    assign universal_serial_clock = sclk_r;
    assign comparator_positive_in = acp_r;
    assign comparator_negative_in = acn_r;
    assign port_e_bit4_toggle     = tog_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_step;
        ce && !srst;
    endsequence

    // irq0 enable must hold over the whole synchroniser span
    sequence s_irq_step;
        ce && !srst && ext_irq0_enable;
    endsequence

    chk_divclk_forced: assert property (s_step ##0 clock_output_fuse |=>
        pe_out_en[`PDEO_PE_DIVCLK_BIT]
        && pe_out_val[`PDEO_PE_DIVCLK_BIT] == $past(io_clock_divided))
        else $error("pe7 not driving divided clock");
    chk_rx_input: assert property (s_step ##0 receiver_enable |=>
        !pe_out_en[`PDEO_PE_RX_BIT])
        else $error("pe0 not forced to input");
    chk_rx_pullup: assert property (s_step ##0 receiver_enable |=>
        pe_pullup[`PDEO_PE_RX_BIT] == ($past(port_e_value[`PDEO_PE_RX_BIT])
                                       && !$past(global_pullup_disable)))
        else $error("pe0 pull-up wrong under receiver");
    chk_tx_drive: assert property (s_step ##0 transmitter_enable |=>
        pe_out_en[`PDEO_PE_TX_BIT] && !pe_pullup[`PDEO_PE_TX_BIT]
        && pe_out_val[`PDEO_PE_TX_BIT] == $past(usart_transmit_data))
        else $error("pe1 not driving transmit data");
    chk_pd_plain: assert property (s_step |=>
        pd_out_en == $past(port_d_direction) && pd_out_val == $past(port_d_value))
        else $error("port d overridden");
    chk_sdo_value: assert property (s_step ##0 serial_three_line_mode |=>
        pe_out_val[`PDEO_PE_SDO_BIT] == $past(serial_data_out)
        && pe_out_en[`PDEO_PE_SDO_BIT] == $past(port_e_direction[`PDEO_PE_SDO_BIT]))
        else $error("pe6 serial output wrong");
    chk_sda_low: assert property (s_step ##0 (serial_two_line_mode
        && port_e_direction[`PDEO_PE_SDA_BIT]) |=>
        !pe_out_val[`PDEO_PE_SDA_BIT] && !pe_pullup[`PDEO_PE_SDA_BIT])
        else $error("sda not open-drain low");
    chk_scl_dir: assert property (s_step ##0 serial_two_line_mode |=>
        pe_out_en[`PDEO_PE_SCL_BIT] == (($past(serial_clock_hold)
                                         || $past(port_e_value[`PDEO_PE_SCL_BIT]))
                                        && $past(port_e_direction[`PDEO_PE_SCL_BIT])))
        else $error("scl direction wrong");
    chk_toggle_copy: assert property (s_step |=>
        port_e_bit4_toggle == $past(serial_clock_toggle))
        else $error("scl toggle control not passed on");
    chk_xclk_async: assert property (s_step ##0 !usart_sync_mode |=>
        !usart_ext_clock_in)
        else $error("usart clock active in async mode");
    chk_xclk_pullup: assert property (s_step ##0 (usart_sync_mode
        && port_e_direction[`PDEO_PE_ACP_BIT]) |=>
        pe_pullup[`PDEO_PE_ACP_BIT] == $past(usart_clock_out))
        else $error("pe2 pull-up not taken by usart clock");
    chk_pin_path: assert property (s_irq_step ##1 s_irq_step ##1 s_irq_step
        |=> ext_irq0_input == $past(pd_pin_in[`PDEO_PD_IRQ0_BIT], `PDEO_PIN_LATENCY))
        else $error("irq0 input path wrong");
endmodule

// File: port_d_e_alternate_function_override_tb.sv
// self-checking bench for the port d/e override block
// assumes the pin model on port e; port d pins driven directly
`timescale 1ns/1ps
module port_d_e_alternate_function_override_tb;
    logic                 clk, srst, ce, pu_dis, slp, irq0_en, fuse, clkdiv, sync, uclk;
    logic                 rx, tx, txd, three, two, sdo, hold, tgl, ssie, pcie, acp_d, acn_d;
    pdeo_pkg::pdeo_byte_t pe_pin, dir, val, pcm, ext_en, ext_val, pe_pu, pe_oe, pe_ov, pcs;
    pdeo_pkg::pdeo_nib_t  pd_pin, pd_val, pd_dir, pd_pu, pd_oe, pd_ov;
    logic                 irq0_in, capt_in, rxd, uclk_in, sdi, sck, acp, acn, tgl_q;
    int                   fails, comparisons;
    typedef struct packed {
        logic [11:0]          ctl;
        pdeo_pkg::pdeo_byte_t dir, val, eoe, eov, epu;
    } pdeo_row_t;
    // ctl: fuse clkdiv rx tx txd two three sdo hold pu_dis sync uclk
    pdeo_row_t rows [12] = '{
        '{12'h000, 8'h0F, 8'hF0, 8'h0F, 8'hF0, 8'hF0},
        '{12'h004, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00},
        '{12'hC00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h00},
        '{12'h800, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00},
        '{12'h200, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01},
        '{12'h204, 8'h01, 8'h01, 8'h00, 8'h01, 8'h00},
        '{12'h100, 8'h00, 8'h02, 8'h02, 8'h00, 8'h00},
        '{12'h030, 8'h40, 8'h00, 8'h40, 8'h40, 8'h00},
        '{12'h040, 8'h00, 8'h30, 8'h00, 8'h30, 8'h10},
        '{12'h058, 8'h30, 8'h00, 8'h30, 8'h00, 8'h00},
        '{12'h040, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00},
        '{12'h003, 8'h04, 8'h00, 8'h04, 8'h00, 8'h04}
    };

    pdeo_top i_pdeo_top (
        .clk(clk), .srst(srst), .ce(ce), .pe_pin_in(pe_pin), .pd_pin_in(pd_pin),
        .port_e_value(val), .port_e_direction(dir), .port_d_value(pd_val),
        .port_d_direction(pd_dir), .global_pullup_disable(pu_dis), .sleep_input_off(slp),
        .ext_irq0_enable(irq0_en), .clock_output_fuse(fuse), .io_clock_divided(clkdiv),
        .usart_sync_mode(sync), .usart_clock_out(uclk), .receiver_enable(rx),
        .transmitter_enable(tx), .usart_transmit_data(txd), .serial_three_line_mode(three),
        .serial_two_line_mode(two), .serial_data_out(sdo), .serial_clock_hold(hold),
        .serial_clock_toggle(tgl), .start_condition_irq_enable(ssie), .pin_change_mask(pcm),
        .pin_change_group0_enable(pcie), .comparator_pos_input_disable(acp_d),
        .comparator_neg_input_disable(acn_d), .pe_pullup(pe_pu), .pe_out_en(pe_oe),
        .pe_out_val(pe_ov), .pd_pullup(pd_pu), .pd_out_en(pd_oe), .pd_out_val(pd_ov),
        .ext_irq0_input(irq0_in), .timer1_capture_input(capt_in), .pin_change_src(pcs),
        .usart_receive_data(rxd), .usart_ext_clock_in(uclk_in), .universal_serial_in(sdi),
        .universal_serial_clock(sck), .comparator_positive_in(acp),
        .comparator_negative_in(acn), .port_e_bit4_toggle(tgl_q)
    );
    pdeo_pin_model i_pdeo_pin_model (
        .clk(clk), .out_en(pe_oe), .out_val(pe_ov), .pull_en(pe_pu),
        .ext_en(ext_en), .ext_val(ext_val), .pin(pe_pin)
    );

    task automatic check(input string name, input pdeo_pkg::pdeo_byte_t seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic give_verdict;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #2000;
        fails++;
        give_verdict();
    end

    initial begin
        fails = 0;
        comparisons = 0;
        {ce, pu_dis, slp, irq0_en, clkdiv, sync, uclk, rx, tx, txd, three, two} = '0;
        {sdo, hold, tgl, ssie, pcie, acp_d, acn_d} = '0;
        {dir, val, pcm, ext_en, ext_val} = '0;
        {pd_pin, pd_val, pd_dir} = '0;
        srst = 1'b1;
        fuse = 1'b1;
        ce = 1'b1;
        // divided clock must track through reset
        for (int k = 0; k < 4; k++) begin
            clkdiv = k[0];
            step(1);
            check("reset clock out", {7'h00, pe_ov[7]}, {7'h00, clkdiv});
            check("reset out en", pe_oe, 8'h80);
        end
        srst = 1'b0;
        step(1);
        foreach (rows[i]) begin
            {fuse, clkdiv, rx, tx, txd, two, three, sdo, hold, pu_dis, sync, uclk} = rows[i].ctl;
            dir = rows[i].dir;
            val = rows[i].val;
            pd_dir = rows[i].dir[3:0];
            pd_val = rows[i].val[3:0];
            step(2);
            check("pe_out_en", pe_oe, rows[i].eoe);
            check("pe_out_val", pe_ov, rows[i].eov);
            check("pe_pullup", pe_pu, rows[i].epu);
            check("pd_out_en", {4'h0, pd_oe}, {4'h0, pd_dir});
            check("pd_out_val", {4'h0, pd_ov}, {4'h0, pd_val});
            check("pd_pullup", {4'h0, pd_pu}, {4'h0, pd_val & ~pd_dir & {4{~pu_dis}}});
        end
        // input paths, default inputs switched off and then back on
        {fuse, two, three, tx, pu_dis, dir, val} = '0;
        {slp, irq0_en, ssie, rx, sync} = '1;
        {pcm, ext_en, ext_val, pd_pin} = {8'hFF, 8'hFF, 8'hA5, 4'h3};
        step(4);
        check("irq0 forced on", {7'h00, irq0_in}, 8'h01);
        check("capture off", {7'h00, capt_in}, 8'h00);
        check("start keeps inputs", pcs, 8'h20);
        check("serial in", {6'h00, sdi, sck}, 8'h02);
        check("comparator ungated", {6'h00, acp, acn}, 8'h02);
        {irq0_en, ssie, pcie, pcm} = {1'b0, 1'b0, 1'b1, 8'h01};
        step(4);
        check("irq0 off", {7'h00, irq0_in}, 8'h00);
        check("mask gates", pcs, 8'h01);
        check("receive data", {7'h00, rxd}, 8'h01);
        check("serial in off", {7'h00, sdi}, 8'h00);
        {slp, sync, acp_d, acn_d, pcm, ext_val} = {4'h3, 8'hFB, 8'hFF};
        step(4);
        check("comparator disable", pcs, 8'hFB);
        check("async no clock", {7'h00, uclk_in}, 8'h00);
        check("capture on", {7'h00, capt_in}, 8'h01);
        // pin-change mask keeps pe2 input on despite the comparator disable
        {acp_d, sync, tgl, pcm} = {3'h7, 8'hFF};
        step(1);
        check("clock toggle", {7'h00, tgl_q}, 8'h01);
        step(3);
        check("sync clock in", {7'h00, uclk_in}, 8'h01);
        check("all sources", pcs, 8'hFF);
        // frozen while clock enable is low
        {ce, tgl, dir} = {2'h0, 8'hFF};
        step(2);
        check("ce hold", {pe_oe[7:1], tgl_q}, 8'h01);
        ce = 1'b1;
        step(1);
        check("receiver forces input", pe_oe, 8'hFE);
        srst = 1'b1;
        step(1);
        check("second reset", pe_oe, 8'h00);
        give_verdict();
    end
endmodule
